/* File: common/rtc_ee_pkg.sv */
// Constants and types shared by the serial access logic
package rtc_ee_pkg;
    // Address byte layout
    localparam logic [3:0] CTRL_CODE    = 4'hD;
    localparam logic [2:0] BLK_CLOCK    = 3'h0;
    localparam logic [2:0] BLK_EE_LO    = 3'h1;
    localparam logic [2:0] BLK_EE_HI    = 3'h2;
    // Storage sizes
    localparam int         CLK_BYTES    = 16;
    localparam int         PAGE_BYTES   = 8;
    localparam int         EE_BYTES     = 512;
    // Bits per byte on the wire, last transmit bit index
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [3:0] TX_LAST      = 4'h7;
    // Reset values
    localparam logic [7:0] PTR_RESET    = 8'h00;
    localparam logic [2:0] BLK_RESET    = 3'h0;
    // Internal write cycle length
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         WR_CYCLE_NS   = 5000000;
    localparam int         WR_CYCLE_CYC  = WR_CYCLE_NS / CLK_PERIOD_NS;
    localparam logic [23:0] BUSY_RESET  = 24'h000000;

    // Serial engine states
    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_WORD,
        ST_WDATA,
        ST_ACK,
        ST_TX,
        ST_MACK
    } state_t;
endpackage

/* File: hdl/rtc_ee_serial.sv */
// Two-wire slave access to clock block and two EEPROM blocks
//
// How it works
// - Byte write: address, word, data, STOP
// - Busy EEPROM cycle: no acknowledge for EEPROM
// - Page write buffers up to eight bytes
// - Unsent page bytes stay unchanged
// - Page pointer rolls over within buffer
// - Clock block write wraps within block
// - Address byte: code, block, direction
// - Master polls; NACK busy, ACK done
// - Clock block always reachable when busy
// - Pointer is last address plus one
// - Master NACK ends read, release line
// - Repeated START keeps new pointer
// - Master ACK advances to next byte
// - EEPROM read pointer wraps in block
// - Byte after write address loads pointer
// - Block bits are upper address bits
`timescale 1ns/100ps
module rtc_ee_serial
    import rtc_ee_pkg::*;
#(
    // cycle count of internal EEPROM write
    parameter int WR_CYCLES = WR_CYCLE_CYC
)
(
    input  wire logic clk,          // System clock
    input  wire logic sys_rst,      // Synchronous reset
    input  wire logic scl_i,        // Bus clock pin
    input  wire logic sda_i,        // Data pin level
    output logic      sda_o,        // Data pin drive value
    output logic      sda_oe_n,     // Low while pulling data low
    output logic      eeprom_busy   // Internal write in progress
);
    // Pin synchronisers and edge history
    logic [2:0] scl_s;              // Sync stages, [2] is history
    logic [2:0] sda_s;              // Sync stages, [2] is history
    // Engine state
    state_t      state;             // Current phase
    state_t      next_state;
    state_t      after;             // Phase after acknowledge bit
    state_t      next_after;
    logic [3:0]  cnt;               // Bit counter
    logic [3:0]  next_cnt;
    logic [7:0]  shreg;             // Shift register
    logic [7:0]  next_shreg;
    logic [7:0]  ptr;               // Word address pointer
    logic [7:0]  next_ptr;
    logic [2:0]  blk;               // Selected block
    logic [2:0]  next_blk;
    logic        drive;             // Pull data line low
    logic        next_drive;
    logic        dirty;             // Page buffer holds data
    logic        next_dirty;
    logic [7:0]  mask;              // Received page bytes
    logic [7:0]  next_mask;
    logic [23:0] busy_cnt;          // Remaining write cycle
    logic [23:0] next_busy_cnt;
    // Storage
    logic [7:0] clk_regs [CLK_BYTES];   // Clock block
    logic [7:0] ee_mem   [EE_BYTES];    // Both EEPROM blocks
    logic [7:0] pbuf     [PAGE_BYTES];  // Page buffer
    // Strobes from the engine to storage
    logic       clk_we;             // Write one clock byte
    logic       pb_we;              // Write one page buffer byte
    logic       commit;             // Copy page buffer to EEPROM
    // Bus conditions
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;
    logic       addr_ok;            // Address byte accepted
    logic [7:0] rd_byte;            // Byte at pointer
    // Pointer after one access, wrapping inside the block
    function automatic logic [7:0] ptr_inc(input logic [2:0] b, input logic [7:0] p);
        logic [3:0] low;
        low = p[3:0] + 4'h1;
        if (b == BLK_CLOCK)
            return {4'h0, low};
        return p + 8'h01;
    endfunction
    // Two flip-flops before any logic; third stage only for edges
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end
        else
        begin
            scl_s <= {scl_s[1:0], scl_i};
            sda_s <= {sda_s[1:0], sda_i};
        end
    end

    // Edges and START/STOP, taken from settled stages only
    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    assign start_ev = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop_ev  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

    // Read data source
    always_comb
    begin
        // block bits select the upper address
        if (blk == BLK_CLOCK)
            rd_byte = clk_regs[ptr[3:0]];
        else
            rd_byte = ee_mem[{blk[1], ptr}];
    end

    // Address byte check
    always_comb
    begin
        addr_ok = 1'b0;
        if (shreg[7:4] == CTRL_CODE)
        begin
            if (shreg[3:1] == BLK_CLOCK)
                addr_ok = 1'b1;
            else if (shreg[3:1] == BLK_EE_LO || shreg[3:1] == BLK_EE_HI)
                addr_ok = ~eeprom_busy;
        end
    end

    // Serial engine next state
    always_comb
    begin
        next_state    = state;
        next_after    = after;
        next_cnt      = cnt;
        next_shreg    = shreg;
        next_ptr      = ptr;
        next_blk      = blk;
        next_drive    = drive;
        next_dirty    = dirty;
        next_mask     = mask;
        clk_we        = 1'b0;
        pb_we         = 1'b0;
        commit        = 1'b0;
        next_busy_cnt = busy_cnt;
        if (busy_cnt != BUSY_RESET)
            next_busy_cnt = busy_cnt - 24'h000001;
        if (stop_ev)
        begin
            next_state = ST_IDLE;
            next_drive = 1'b0;
            if (dirty)
            begin
                commit        = 1'b1;
                next_dirty    = 1'b0;
                next_busy_cnt = 24'(WR_CYCLES);
            end
        end
        else if (start_ev)
        begin
            next_state = ST_ADDR;
            next_cnt   = 4'h0;
            next_drive = 1'b0;
            next_dirty = 1'b0;
            next_mask  = 8'h00;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    // Wait for START
                end
                ST_ADDR, ST_WORD, ST_WDATA:
                begin
                    // Receive a byte, MSB first
                    if (scl_rise)
                    begin
                        next_shreg = {shreg[6:0], sda_s[1]};
                        next_cnt   = cnt + 4'h1;
                    end
                    else if (scl_fall && cnt == BYTE_BITS)
                    begin
                        next_cnt   = 4'h0;
                        next_state = ST_ACK;
                        next_drive = 1'b1;
                        if (state == ST_ADDR)
                        begin
                            if (addr_ok)
                            begin
                                next_blk   = shreg[3:1];
                                next_after = shreg[0] ? ST_TX : ST_WORD;
                            end
                            else
                            begin
                                next_state = ST_IDLE;
                                next_drive = 1'b0;
                            end
                        end
                        else if (state == ST_WORD)
                        begin
                            next_ptr   = shreg;
                            next_after = ST_WDATA;
                            next_mask  = 8'h00;
                        end
                        else if (blk == BLK_CLOCK)
                        begin
                            clk_we   = 1'b1;
                            next_ptr = ptr_inc(blk, ptr);
                        end
                        else
                        begin
                            pb_we      = 1'b1;
                            next_dirty = 1'b1;
                            next_mask[ptr[2:0]] = 1'b1;
                            next_ptr   = {ptr[7:3], ptr[2:0] + 3'h1};
                        end
                    end
                end
                ST_ACK:
                begin
                    // Acknowledge held through ninth clock
                    if (scl_fall)
                    begin
                        next_drive = 1'b0;
                        next_state = after;
                        if (after == ST_TX)
                        begin
                            next_shreg = rd_byte;
                            next_drive = ~rd_byte[7];
                            next_ptr   = ptr_inc(blk, ptr);
                            next_cnt   = 4'h0;
                        end
                    end
                end
                ST_TX:
                begin
                    // Shift out on each falling edge
                    if (scl_fall)
                    begin
                        next_cnt = cnt + 4'h1;
                        if (cnt == TX_LAST)
                        begin
                            next_state = ST_MACK;
                            next_drive = 1'b0;
                        end
                        else
                        begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_drive = ~shreg[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        if (sda_s[1])
                            next_state = ST_IDLE;
                        else
                        begin
                            next_state = ST_ACK;
                            next_after = ST_TX;
                        end
                    end
                end
            endcase
        end
    end

    // Serial engine registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state    <= ST_IDLE;
            after    <= ST_IDLE;
            cnt      <= 4'h0;
            shreg    <= 8'h00;
            ptr      <= PTR_RESET;
            blk      <= BLK_RESET;
            drive    <= 1'b0;
            dirty    <= 1'b0;
            mask     <= 8'h00;
            busy_cnt <= BUSY_RESET;
        end
        else
        begin
            state    <= next_state;
            after    <= next_after;
            cnt      <= next_cnt;
            shreg    <= next_shreg;
            ptr      <= next_ptr;
            blk      <= next_blk;
            drive    <= next_drive;
            dirty    <= next_dirty;
            mask     <= next_mask;
            busy_cnt <= next_busy_cnt;
        end
    end

    // Storage writes; arrays are not reset, which keeps them as RAM
    always_ff @(posedge clk)
    begin
        if (clk_we)
            clk_regs[ptr[3:0]] <= shreg;
        if (pb_we)
            pbuf[ptr[2:0]] <= shreg;
        // only received page bytes are copied
        if (commit)
        begin
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
                if (mask[i])
                    ee_mem[{blk[1], ptr[7:3], 3'(i)}] <= pbuf[i];
            end
        end
    end

    // Pin and status outputs; open drain, so the drive value stays low
    assign sda_o       = 1'b0;
    assign sda_oe_n    = ~drive;
    assign eeprom_busy = (busy_cnt != BUSY_RESET);

endmodule

/* File: verification/rtc_ee_serial_chk.sv */
// Port assertions for the serial access block
`timescale 1ns/100ps
module rtc_ee_serial_chk
#(
    parameter int WR_CYCLES = 1000
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic eeprom_busy
);
    logic [23:0] busy_cnt;      // Cycles busy has stood so far
    logic [23:0] next_busy_cnt; // Next count
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Count busy cycles; a count beats a long repetition
    always_comb
    begin
        next_busy_cnt = eeprom_busy ? busy_cnt + 24'h1 : 24'h0;
    end
    always_ff @(posedge clk)
    begin
        busy_cnt <= sys_rst ? 24'h0 : next_busy_cnt;
    end
    // Pull begins, then stands at least six clock cycles
    sequence pull_start; $fell(sda_oe_n); endsequence
    sequence pull_hold; !sda_oe_n [*6]; endsequence
    reset_quiet_a: assert property ($fell(sys_rst) |-> sda_oe_n && !eeprom_busy)
        else $error("outputs not quiet after reset");
    ack_hold_a: assert property (pull_start |-> pull_hold)
        else $error("pull shorter than a bit slot");
    hold_high_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n))
        else $error("data drive moved while clock high");
    drive_low_a: assert property (!sda_oe_n |-> !sda_o)
        else $error("data pin driven high");
    busy_start_a: assert property ($rose(eeprom_busy) |-> scl_i && sda_i && $past(sda_oe_n, 2))
        else $error("busy began outside a stop");
    busy_len_a: assert property ($fell(eeprom_busy) |-> busy_cnt == 24'(WR_CYCLES))
        else $error("write cycle length wrong");
    busy_bound_a: assert property (eeprom_busy |-> busy_cnt < 24'(WR_CYCLES))
        else $error("write cycle overran");
    busy_gap_a: assert property ($fell(eeprom_busy) |-> !eeprom_busy [*8])
        else $error("busy restarted without a stop");
endmodule
bind rtc_ee_serial rtc_ee_serial_chk #(.WR_CYCLES(WR_CYCLES)) chk_i (.clk(clk),
    .sys_rst(sys_rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .eeprom_busy(eeprom_busy));

/* File: verification/i2c_master_model.sv */
// Bus master model that paces frames from the system clock
`timescale 1ns/100ps
module i2c_master_model
(
    input  wire logic clk,   // System clock, paces the bus
    input  wire logic sda,   // Resolved data line
    output logic      scl,   // Bus clock, stands high between frames
    output logic      sda_m  // Low while the master pulls data
);
    // Idle bus: both lines released
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Wait on clock falls; all changes land there
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic start();
        scl = 1'b0;
        tick(1);
        sda_m = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(2);
        sda_m = 1'b0;
        tick(2);
    endtask
    // stop: data rises while the clock stands high
    task automatic stop();
        scl = 1'b0;
        tick(1);
        sda_m = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(2);
        sda_m = 1'b1;
        tick(4);
    endtask
    // nine slots MSB first; data moves only while clock is low
    task automatic xb(input logic [8:0] v, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            scl = 1'b0;
            tick(1);
            sda_m = v[i];
            tick(3);
            scl = 1'b1;
            tick(2);
            r[i] = sda;
            tick(2);
        end
    endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the serial access block
`timescale 1ns/100ps
module tb_top
    import rtc_ee_pkg::*;
;
    logic       clk = 1'b0;     // System clock
    logic       sys_rst = 1'b1; // Synchronous reset
    logic       scl;            // Bus clock from master
    logic       sda_m;          // Master pull
    logic       sda_o;          // Device drive value
    logic       sda_oe_n;       // Device pull, low active
    logic       eeprom_busy;    // Internal write running
    wire        sda;            // Line with pull-up
    int         err_total = 0;
    int         n_compared = 0;
    logic [8:0] r;              // Last nine slots seen
    assign sda = sda_m & (sda_oe_n | sda_o);
    // Long write cycle so polling can catch it busy
    rtc_ee_serial #(.WR_CYCLES(1000)) dut (.clk(clk), .sys_rst(sys_rst), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .eeprom_busy(eeprom_busy));
    i2c_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic close_out();
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Address byte; the wire shows our bits then the device answer
    task automatic addr(input logic [2:0] blk, input logic rw, input logic ack);
        m.start();
        m.xb({CTRL_CODE, blk, rw, 1'b1}, r);
        chk(r, {CTRL_CODE, blk, rw, ack});
    endtask
    task automatic wd(input logic [7:0] b);
        m.xb({b, 1'b1}, r);
        chk(r, {b, 1'b0});
    endtask
    task automatic setp(input logic [2:0] blk, input logic [7:0] w);
        addr(blk, 1'b0, 1'b0);
        wd(w);
    endtask
    // Released ninth slot shows the device let go
    task automatic rd(input logic [7:0] exp, input logic last);
        m.xb({8'hFF, last}, r);
        chk(r, {exp, last});
    endtask
    task automatic idle();
        for (int i = 0; i < 2000 && eeprom_busy !== 1'b0; i++)
            m.tick(1);
        chk({8'h00, eeprom_busy}, 9'h000);
    endtask
    // Clock block burst wraps past its end, read back at random address
    task automatic t_clock();
        setp(BLK_CLOCK, 8'h0E);
        wd(8'h11);
        wd(8'h22);
        wd(8'h33);
        m.stop();
        setp(BLK_CLOCK, 8'h0E);
        addr(BLK_CLOCK, 1'b1, 1'b0);
        rd(8'h11, 1'b0);
        rd(8'h22, 1'b0);
        rd(8'h33, 1'b1);
        m.stop();
    endtask
    // Ten bytes roll within one page; polls refused; clock still reachable
    task automatic t_page();
        logic [7:0] j;
        setp(BLK_EE_LO, 8'h05);
        for (int i = 0; i < 10; i++)
            wd(8'hA0 + 8'(i));
        m.stop();
        chk({8'h00, eeprom_busy}, 9'h001);
        addr(BLK_EE_LO, 1'b0, 1'b1);
        addr(BLK_EE_HI, 1'b1, 1'b1);
        setp(BLK_CLOCK, 8'h0E);
        addr(BLK_CLOCK, 1'b1, 1'b0);
        rd(8'h11, 1'b1);
        m.stop();
        idle();
        addr(BLK_EE_LO, 1'b0, 1'b0);
        m.stop();
        setp(BLK_EE_LO, 8'h00);
        addr(BLK_EE_LO, 1'b1, 1'b0);
        for (int k = 0; k < 8; k++)
        begin
            j = 8'((k + 3) % 8);
            rd(8'hA0 + ((j < 8'h02) ? j + 8'h08 : j), k == 7);
        end
        m.stop();
    endtask
    // Byte write keeps neighbours; then current address read
    task automatic t_byte();
        setp(BLK_EE_LO, 8'h01);
        wd(8'h5A);
        m.stop();
        idle();
        setp(BLK_EE_LO, 8'h00);
        addr(BLK_EE_LO, 1'b1, 1'b0);
        rd(8'hA3, 1'b0);
        rd(8'h5A, 1'b0);
        rd(8'hA5, 1'b1);
        m.stop();
        addr(BLK_EE_LO, 1'b1, 1'b0);
        rd(8'hA6, 1'b1);
        m.stop();
    endtask
    // Read past the block end stays in the same block
    task automatic t_wrap();
        setp(BLK_EE_HI, 8'hFF);
        wd(8'hC1);
        m.stop();
        idle();
        setp(BLK_EE_HI, 8'h00);
        wd(8'hC2);
        m.stop();
        idle();
        setp(BLK_EE_HI, 8'hFF);
        addr(BLK_EE_HI, 1'b1, 1'b0);
        rd(8'hC1, 1'b0);
        rd(8'hC2, 1'b1);
        m.stop();
    endtask
    // Undefined blocks and a foreign code get no answer
    task automatic t_refuse();
        for (int b = 3; b < 8; b++)
            addr(3'(b), 1'b0, 1'b1);
        m.start();
        m.xb({4'hC, BLK_CLOCK, 2'b11}, r);
        chk(r, {4'hC, BLK_CLOCK, 2'b11});
        m.stop();
    endtask
    // Main sequence
    initial
    begin
        m.tick(6);
        sys_rst = 1'b0;
        m.tick(4);
        t_refuse();
        t_clock();
        t_page();
        t_byte();
        t_wrap();
        close_out();
    end
    // Watchdog cuts a hang short
    initial
    begin
        repeat (60000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule
